// File: core/optg_pkg.sv
package optg_pkg;

    // ------------------------------------------------------------------
    // Widths and FIFO depth
    // ------------------------------------------------------------------
    localparam int ADDR_W    = 12;
    localparam int DATA_W    = 32;
    localparam int PAT_W     = 20;
    localparam int LANE_W    = 32;
    localparam int NARROW_W  = 16;
    localparam int PAD_W     = 12;
    localparam int FIFO_DEPTH = 8;

    // ------------------------------------------------------------------
    // Register indices (byte address is four times the index)
    // ------------------------------------------------------------------
    localparam logic [ADDR_W-1:0] IDX_PATTERN_CONTROL = 12'h14a;
    localparam logic [ADDR_W-1:0] IDX_USER_LOW        = 12'h14b;
    localparam logic [ADDR_W-1:0] IDX_USER_MID        = 12'h14c;
    localparam logic [ADDR_W-1:0] IDX_USER_HIGH       = 12'h14d;
    localparam logic [ADDR_W-1:0] IDX_OUTPUT_WIDTH    = 12'h162;
    localparam logic [ADDR_W-1:0] IDX_STATUS          = 12'h170;

    // ------------------------------------------------------------------
    // Field positions and reset values
    // ------------------------------------------------------------------
    localparam int CTRL_TYPE_LSB   = 0;
    localparam int CTRL_TYPE_W     = 3;
    localparam int CTRL_CLKSEL_BIT = 4;
    localparam int WIDTH_SEL_BIT   = 1;
    localparam int USER_HIGH_W     = 4;
    localparam logic             RESET_CLKSEL = 1'b0;
    localparam logic [2:0]       RESET_TYPE   = 3'h0;
    localparam logic [PAT_W-1:0] RESET_USER   = 20'h00000;
    localparam logic             RESET_WIDE   = 1'b0;

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        PAT_OFF         = 3'b000,
        PAT_RAMP_ONE    = 3'b001,
        PAT_RAMP_STEP   = 3'b010,
        PAT_UNUSED_A    = 3'b011,
        PAT_STATIC      = 3'b100,
        PAT_TOGGLE_INV  = 3'b101,
        PAT_TOGGLE_ZERO = 3'b110,
        PAT_UNUSED_B    = 3'b111
    } optg_pattern_type;

    typedef struct packed {
        logic             clkSel;
        optg_pattern_type patType;
        logic [PAT_W-1:0] userValue;
        logic             wideOut;
    } optg_cfg_type;

    typedef struct packed {
        logic [LANE_W-1:0] word;
        logic              isPattern;
    } optg_word_type;

endpackage

// File: core/optg_fifo.sv
`timescale 1ns/1ps
module optg_fifo #(
    parameter int WIDTH = 33,
    parameter int DEPTH = 8
) (
    // Clock and reset
    input  wire logic             ref_clk,
    input  wire logic             sys_rst,
    // Fill side
    input  wire logic [WIDTH-1:0] inData,
    input  wire logic             inValid,
    output logic                  inReady,
    // Drain side
    output logic [WIDTH-1:0]      outData,
    output logic                  outValid,
    input  wire logic             outReady
);
    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH + 1);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [PW-1:0]    wrPtr;
    logic [PW-1:0]    rdPtr;
    logic [CW-1:0]    count;
    logic [CW-1:0]    next_count;
    wire              pushOk = inValid & inReady;
    wire              popOk  = outValid & outReady;

    assign next_count = count + CW'(pushOk) - CW'(popOk);
    assign outData    = mem[rdPtr];

    always_ff @(posedge ref_clk) begin
        if (pushOk) begin
            mem[wrPtr] <= inData;
        end
    end

    // Flags are registered from the next count, so full and empty are exact
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            wrPtr    <= '0;
            rdPtr    <= '0;
            count    <= '0;
            inReady  <= 1'b0;
            outValid <= 1'b0;
        end else begin
            wrPtr    <= pushOk ? PW'(wrPtr + PW'(1)) : wrPtr;
            rdPtr    <= popOk ? PW'(rdPtr + PW'(1)) : rdPtr;
            count    <= next_count;
            inReady  <= (next_count != CW'(DEPTH));
            outValid <= (next_count != '0);
        end
    end
endmodule // optg_fifo

// File: core/optg_engine.sv
`timescale 1ns/1ps
module optg_engine (
    // Clock and reset
    input  wire logic                          ref_clk,
    input  wire logic                          sys_rst,
    // Configuration and step
    input  wire optg_pkg::optg_cfg_type        cfg,
    input  wire logic                          advance,
    // Pattern word
    output logic [optg_pkg::PAT_W-1:0]         patWord
);
    logic [optg_pkg::PAT_W-1:0]   acc;
    logic [optg_pkg::PAT_W-1:0]   next_acc;
    logic                         phase;
    optg_pkg::optg_pattern_type   lastType;
    logic [optg_pkg::PAT_W:0]     sumOne;
    logic [optg_pkg::PAT_W:0]     sumStep;
    wire                          restart = (cfg.patType != lastType);
    // A type change starts from zero in its very first cycle, even when
    // that cycle already pushes a word, so no word is sent twice
    wire [optg_pkg::PAT_W-1:0]    accNow   = restart ? '0 : acc;
    wire                          phaseNow = restart ? 1'b0 : phase;

    // Ramps drop the carry so they wrap at the 20-bit level
    assign sumOne  = {1'b0, accNow} + 21'h000001;
    assign sumStep = {1'b0, accNow} + {1'b0, cfg.userValue};

    always_comb begin
        next_acc = accNow;
        case (cfg.patType)
            optg_pkg::PAT_RAMP_ONE:  next_acc = sumOne[optg_pkg::PAT_W-1:0];
            optg_pkg::PAT_RAMP_STEP: next_acc = sumStep[optg_pkg::PAT_W-1:0];
            default:                 next_acc = accNow;
        endcase
    end

    // User value is read as step, static word or toggle operand
    always_comb begin
        case (cfg.patType)
            optg_pkg::PAT_RAMP_ONE:    patWord = accNow;
            optg_pkg::PAT_RAMP_STEP:   patWord = accNow;
            optg_pkg::PAT_STATIC:      patWord = cfg.userValue;
            optg_pkg::PAT_TOGGLE_INV:  patWord = phaseNow ? ~cfg.userValue
                                                          : cfg.userValue;
            optg_pkg::PAT_TOGGLE_ZERO: patWord = phaseNow ? '0
                                                          : cfg.userValue;
            default:                   patWord = '0;
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            acc      <= '0;
            phase    <= 1'b0;
            lastType <= optg_pkg::PAT_OFF;
        end else begin
            lastType <= cfg.patType;
            acc      <= advance ? next_acc : accNow;
            phase    <= advance ? ~phaseNow : phaseNow;
        end
    end
endmodule // optg_engine

// File: core/optg_top.sv
`timescale 1ns/1ps
module optg_top (
    // Clock and reset
    input  wire logic                        ref_clk,
    input  wire logic                        sys_rst,
    // APB slave
    input  wire logic                        psel,
    input  wire logic                        penable,
    input  wire logic                        pwrite,
    input  wire logic [optg_pkg::ADDR_W-1:0] paddr,
    input  wire logic [optg_pkg::DATA_W-1:0] pwdata,
    output logic [optg_pkg::DATA_W-1:0]      prdata,
    output logic                             pready,
    output logic                             pslverr,
    // Pattern clock sources
    input  wire logic                        sampleTick,
    input  wire logic                        decimTick,
    // Converted data in
    input  wire logic [optg_pkg::LANE_W-1:0] convWord,
    input  wire logic                        convValid,
    output logic                             convReady,
    // Output lanes
    output logic [optg_pkg::LANE_W-1:0]      laneWord,
    output logic                             lanePattern,
    output logic                             laneValid,
    input  wire logic                        laneReady,
    // Status
    output logic                             genActive
);
    // ------------------------------------------------------------------
    // Configuration registers and internal signals
    // ------------------------------------------------------------------
    optg_pkg::optg_cfg_type         cfg;
    logic [optg_pkg::PAT_W-1:0]     patWord;
    optg_pkg::optg_word_type        fifoInData;
    optg_pkg::optg_word_type        fifoOutData;
    logic                           fifoInReady;
    logic                           fifoOutValid;
    logic [optg_pkg::LANE_W-1:0]    fmtWord;
    logic [optg_pkg::DATA_W-1:0]    readMux;

    // ------------------------------------------------------------------
    // APB decode
    // ------------------------------------------------------------------
    wire [optg_pkg::ADDR_W-1:0] addrCtrl  =
        {optg_pkg::IDX_PATTERN_CONTROL[optg_pkg::ADDR_W-3:0], 2'b00};
    wire [optg_pkg::ADDR_W-1:0] addrLow   =
        {optg_pkg::IDX_USER_LOW[optg_pkg::ADDR_W-3:0], 2'b00};
    wire [optg_pkg::ADDR_W-1:0] addrMid   =
        {optg_pkg::IDX_USER_MID[optg_pkg::ADDR_W-3:0], 2'b00};
    wire [optg_pkg::ADDR_W-1:0] addrHigh  =
        {optg_pkg::IDX_USER_HIGH[optg_pkg::ADDR_W-3:0], 2'b00};
    wire [optg_pkg::ADDR_W-1:0] addrWidth =
        {optg_pkg::IDX_OUTPUT_WIDTH[optg_pkg::ADDR_W-3:0], 2'b00};
    wire [optg_pkg::ADDR_W-1:0] addrStat  =
        {optg_pkg::IDX_STATUS[optg_pkg::ADDR_W-3:0], 2'b00};

    wire hitCtrl    = (paddr == addrCtrl);
    wire hitLow     = (paddr == addrLow);
    wire hitMid     = (paddr == addrMid);
    wire hitHigh    = (paddr == addrHigh);
    wire hitWidth   = (paddr == addrWidth);
    wire hitStat    = (paddr == addrStat);
    wire hitRw      = hitCtrl | hitLow | hitMid | hitHigh | hitWidth;
    wire hitAny     = hitRw | hitStat;
    // One wait state: the answer is registered in the first access cycle
    wire accessWait = psel & penable & ~pready;
    wire xferDone   = psel & penable & pready;
    wire writeTake  = xferDone & pwrite & ~pslverr;
    wire badAccess  = ~hitAny | (pwrite & hitStat);

    // ------------------------------------------------------------------
    // Read mux
    // ------------------------------------------------------------------
    wire [7:0] ctrlByte = {3'h0, cfg.clkSel, 1'b0, cfg.patType};
    wire [7:0] highByte = {4'h0, cfg.userValue[19:16]};

    always_comb begin
        readMux = '0;
        if (hitCtrl) begin
            readMux = {24'h000000, ctrlByte};
        end else if (hitLow) begin
            readMux = {24'h000000, cfg.userValue[7:0]};
        end else if (hitMid) begin
            readMux = {24'h000000, cfg.userValue[15:8]};
        end else if (hitHigh) begin
            readMux = {24'h000000, highByte};
        end else if (hitWidth) begin
            readMux = {30'h00000000, cfg.wideOut, 1'b0};
        end else if (hitStat) begin
            readMux = {11'h000, patWord, genActive};
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= '0;
        end else begin
            pready  <= accessWait;
            pslverr <= accessWait & badAccess;
            prdata  <= (accessWait & ~pwrite) ? readMux : '0;
        end
    end

    // Reserved bits are not stored and read back as zero
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            cfg.clkSel    <= optg_pkg::RESET_CLKSEL;
            cfg.patType   <= optg_pkg::optg_pattern_type'(
                                 optg_pkg::RESET_TYPE);
            cfg.userValue <= optg_pkg::RESET_USER;
            cfg.wideOut   <= optg_pkg::RESET_WIDE;
        end else if (writeTake) begin
            if (hitCtrl) begin
                cfg.clkSel  <= pwdata[optg_pkg::CTRL_CLKSEL_BIT];
                cfg.patType <= optg_pkg::optg_pattern_type'(
                    pwdata[optg_pkg::CTRL_TYPE_LSB +:
                           optg_pkg::CTRL_TYPE_W]);
            end
            if (hitLow) begin
                cfg.userValue[7:0]   <= pwdata[7:0];
            end
            if (hitMid) begin
                cfg.userValue[15:8]  <= pwdata[7:0];
            end
            if (hitHigh) begin
                cfg.userValue[19:16] <=
                    pwdata[optg_pkg::USER_HIGH_W-1:0];
            end
            if (hitWidth) begin
                cfg.wideOut <= pwdata[optg_pkg::WIDTH_SEL_BIT];
            end
        end
    end

    // ------------------------------------------------------------------
    // Pattern source and formatting
    // ------------------------------------------------------------------
    wire genOn   = (cfg.patType != optg_pkg::PAT_OFF);
    wire patTick = cfg.clkSel ? decimTick : sampleTick;
    // The generator stalls while the FIFO is full, so no word is skipped
    wire advance = genOn & patTick & fifoInReady;

    optg_engine u_engine (
        .ref_clk (ref_clk),
        .sys_rst (sys_rst),
        .cfg     (cfg),
        .advance (advance),
        .patWord (patWord)
    );

    assign fmtWord = cfg.wideOut
        ? {patWord, {optg_pkg::PAD_W{1'b0}}}
        : {16'h0000, patWord[optg_pkg::PAT_W-1 -:
                             optg_pkg::NARROW_W]};

    // Converted samples are consumed and replaced while a pattern runs
    assign fifoInData.word      = genOn ? fmtWord : convWord;
    assign fifoInData.isPattern = genOn;
    wire   fifoInValid          = genOn ? patTick : convValid;
    wire   fifoOutReady         = ~laneValid | laneReady;

    optg_fifo #(
        .WIDTH ($bits(optg_pkg::optg_word_type)),
        .DEPTH (optg_pkg::FIFO_DEPTH)
    ) u_fifo (
        .ref_clk  (ref_clk),
        .sys_rst  (sys_rst),
        .inData   (fifoInData),
        .inValid  (fifoInValid),
        .inReady  (fifoInReady),
        .outData  (fifoOutData),
        .outValid (fifoOutValid),
        .outReady (fifoOutReady)
    );

    assign convReady = fifoInReady;

    // ------------------------------------------------------------------
    // Output stage
    // ------------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            laneValid   <= 1'b0;
            laneWord    <= '0;
            lanePattern <= 1'b0;
            genActive   <= 1'b0;
        end else begin
            genActive <= genOn;
            if (fifoOutReady) begin
                laneValid   <= fifoOutValid;
                laneWord    <= fifoOutData.word;
                lanePattern <= fifoOutData.isPattern;
            end
        end
    end

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    sequence s_setup;
        psel && !penable;
    endsequence

    sequence s_access_wait;
        psel && penable && !pready;
    endsequence

    property p_apb_answer;
        @(posedge ref_clk) disable iff (sys_rst)
        s_setup ##1 s_access_wait |=> pready;
    endproperty
    a_apb_answer: assert property (p_apb_answer)
        else $error("APB access not answered after one wait");

    property p_src_sample;
        @(posedge ref_clk) disable iff (sys_rst)
        genOn && !cfg.clkSel && decimTick && !sampleTick |-> !fifoInValid;
    endproperty
    a_src_sample: assert property (p_src_sample)
        else $error("Pattern pushed on wrong clock source");

    property p_src_decim;
        @(posedge ref_clk) disable iff (sys_rst)
        genOn && cfg.clkSel && sampleTick && !decimTick |-> !advance;
    endproperty
    a_src_decim: assert property (p_src_decim)
        else $error("Pattern advanced on sample tick in decimation mode");

    property p_off_pass;
        @(posedge ref_clk) disable iff (sys_rst)
        cfg.patType == optg_pkg::PAT_OFF |->
            fifoInData.word == convWord && !fifoInData.isPattern;
    endproperty
    a_off_pass: assert property (p_off_pass)
        else $error("Normal data not passed while generator off");

    property p_narrow;
        @(posedge ref_clk) disable iff (sys_rst)
        genOn && !cfg.wideOut |->
            fifoInData.word == {16'h0000, patWord[19:4]};
    endproperty
    a_narrow: assert property (p_narrow)
        else $error("Narrow word is not upper pattern bits");

    property p_wide;
        @(posedge ref_clk) disable iff (sys_rst)
        genOn && cfg.wideOut |-> fifoInData.word == {patWord, 12'h000};
    endproperty
    a_wide: assert property (p_wide)
        else $error("Wide word is not zero padded pattern");

    sequence s_steady(optg_pkg::optg_pattern_type t);
        advance && cfg.patType == t && $stable(cfg.patType)
            && $stable(cfg.userValue);
    endsequence

    property p_ramp_one;
        @(posedge ref_clk) disable iff (sys_rst)
        s_steady(optg_pkg::PAT_RAMP_ONE) ##1 $stable(cfg.patType) |->
            patWord == 20'($past(patWord) + 20'h00001);
    endproperty
    a_ramp_one: assert property (p_ramp_one)
        else $error("Unit ramp did not step by one");

    property p_ramp_step;
        @(posedge ref_clk) disable iff (sys_rst)
        s_steady(optg_pkg::PAT_RAMP_STEP) ##1
            ($stable(cfg.patType) && $stable(cfg.userValue)) |->
            patWord == 20'($past(patWord) + cfg.userValue);
    endproperty
    a_ramp_step: assert property (p_ramp_step)
        else $error("Step ramp did not step by user value");

    property p_static;
        @(posedge ref_clk) disable iff (sys_rst)
        cfg.patType == optg_pkg::PAT_STATIC |-> patWord == cfg.userValue;
    endproperty
    a_static: assert property (p_static)
        else $error("Static pattern differs from user value");

    property p_toggle_inv;
        @(posedge ref_clk) disable iff (sys_rst)
        s_steady(optg_pkg::PAT_TOGGLE_INV) ##1
            ($stable(cfg.patType) && $stable(cfg.userValue)) |->
            patWord == ~$past(patWord);
    endproperty
    a_toggle_inv: assert property (p_toggle_inv)
        else $error("Inverse toggle did not invert");

    property p_toggle_zero;
        @(posedge ref_clk) disable iff (sys_rst)
        s_steady(optg_pkg::PAT_TOGGLE_ZERO) ##1
            ($stable(cfg.patType) && $stable(cfg.userValue)) |->
            patWord == (($past(patWord) == cfg.userValue)
                        ? 20'h00000 : cfg.userValue);
    endproperty
    a_toggle_zero: assert property (p_toggle_zero)
        else $error("Zero toggle did not alternate");

    property p_hold;
        @(posedge ref_clk) disable iff (sys_rst)
        !advance ##1 ($stable(cfg.patType) && $stable(cfg.userValue))
            |-> $stable(patWord);
    endproperty
    a_hold: assert property (p_hold)
        else $error("Pattern moved without a pattern tick");

    property p_high_nibble;
        @(posedge ref_clk) disable iff (sys_rst)
        xferDone && !pwrite && hitHigh |-> prdata[31:4] == 28'h0000000;
    endproperty
    a_high_nibble: assert property (p_high_nibble)
        else $error("Upper bits of top user byte not zero");

    property p_lane_hold;
        @(posedge ref_clk) disable iff (sys_rst)
        laneValid && !laneReady |=> laneValid && $stable(laneWord);
    endproperty
    a_lane_hold: assert property (p_lane_hold)
        else $error("Lane word dropped under back pressure");
endmodule // optg_top

// File: tb/optg_rx.sv
`timescale 1ns/1ps
module optg_rx (
    // Clock and reset
    input  wire logic        ref_clk,
    input  wire logic        sys_rst,
    // Lane side
    input  wire logic [31:0] laneWord,
    input  wire logic        lanePattern,
    input  wire logic        laneValid,
    output logic             laneReady,
    // Bench control
    input  wire logic        hold,
    input  wire logic        clear,
    output logic [3:0]       count
);
    logic [32:0] seen [0:15];

    // ------------------------------------------------------------------
    // Capture, stalling while held
    // ------------------------------------------------------------------
    assign laneReady = !hold;

    always_ff @(posedge ref_clk) begin
        if (sys_rst || clear) begin
            count <= 4'h0;
        end else if (laneValid && laneReady && count != 4'hf) begin
            seen[count] <= {lanePattern, laneWord};
            count       <= count + 4'h1;
        end
    end
endmodule // optg_rx

// File: tb/tb.sv
`timescale 1ns/1ps
module tb;
    typedef struct packed {
        logic [2:0] typ; logic [19:0] user; logic wide, clk, hold;
    } optg_row_type;
    logic ref_clk = 0, sys_rst = 1, psel = 0, penable = 0, pwrite = 0;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, convWord = 0, laneWord, rdata;
    logic pready, pslverr, rerr, convReady, lanePattern, laneValid;
    logic sampleTick = 0, decimTick = 0, convValid = 0, laneReady;
    logic genActive, hold = 0, clear = 0;
    logic [3:0] count;
    int errors = 0, n_tests = 0;
    optg_row_type rows [5] = '{
        '{3'h1, 20'h00000, 1'b1, 1'b0, 1'b1},
        '{3'h2, 20'hc0000, 1'b1, 1'b1, 1'b0},
        '{3'h4, 20'h12345, 1'b0, 1'b0, 1'b0},
        '{3'h5, 20'h0f0f5, 1'b1, 1'b1, 1'b0},
        '{3'h6, 20'habcde, 1'b0, 1'b0, 1'b1}};

    always #25 ref_clk = ~ref_clk;
    optg_top u_optg_top (.ref_clk(ref_clk), .sys_rst(sys_rst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .sampleTick(sampleTick), .decimTick(decimTick), .convWord(convWord),
        .convValid(convValid), .convReady(convReady), .laneWord(laneWord),
        .lanePattern(lanePattern), .laneValid(laneValid),
        .laneReady(laneReady), .genActive(genActive));
    optg_rx u_optg_rx (.ref_clk(ref_clk), .sys_rst(sys_rst),
        .laneWord(laneWord), .lanePattern(lanePattern),
        .laneValid(laneValid), .laneReady(laneReady), .hold(hold),
        .clear(clear), .count(count));

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    function automatic logic [11:0] ba(logic [11:0] i);
        return {i[9:0], 2'b00};
    endfunction
    function automatic logic [19:0] exp_pat(logic [2:0] t, logic [19:0] u,
                                            int k);
        case (t)
            3'h1: return 20'(k);
            3'h2: return 20'(u * k);
            3'h5: return k[0] ? ~u : u;
            3'h6: return k[0] ? 20'h0 : u;
            default: return u;
        endcase
    endfunction
    task automatic chk(string name, logic [32:0] seen, logic [32:0] exp);
        n_tests++;
        if (seen !== exp) begin
            errors++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic apb(logic w, logic [11:0] a, logic [31:0] d);
        @(posedge ref_clk);
        psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge ref_clk);
        penable <= 1;
        do @(posedge ref_clk); while (pready !== 1'b1);
        rdata = prdata;
        rerr = pslverr;
        psel <= 0;
        penable <= 0;
    endtask
    task automatic end_of_test();
        $display("errors %0d n_tests %0d", errors, n_tests);
        if (errors == 0 && n_tests > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task automatic run_row(optg_row_type r);
        logic [19:0] p;
        logic [32:0] e;
        apb(1, ba(optg_pkg::IDX_PATTERN_CONTROL), 32'h0);
        repeat (12) @(posedge ref_clk);
        apb(1, ba(optg_pkg::IDX_USER_LOW), {24'h0, r.user[7:0]});
        apb(1, ba(optg_pkg::IDX_USER_MID), {24'h0, r.user[15:8]});
        apb(1, ba(optg_pkg::IDX_USER_HIGH), {28'h0, r.user[19:16]});
        apb(1, ba(optg_pkg::IDX_OUTPUT_WIDTH), {30'h0, r.wide, 1'b0});
        sampleTick <= !r.clk; decimTick <= r.clk; hold <= r.hold;
        clear <= 1;
        @(posedge ref_clk) clear <= 0;
        apb(1, ba(optg_pkg::IDX_PATTERN_CONTROL),
            {27'h0, r.clk, 1'b0, r.typ});
        if (r.hold) begin
            repeat (16) @(posedge ref_clk);
            chk("convReady", convReady, 0);
            hold <= 0;
        end
        repeat (12) @(posedge ref_clk);
        chk("count", count >= 4, 1);
        chk("genActive", genActive, 1);
        for (int k = 0; k < 4; k++) begin
            p = exp_pat(r.typ, r.user, k);
            e = {1'b1, r.wide ? {p, 12'h0} : {16'h0, p[19:4]}};
            chk("lane", u_optg_rx.seen[k], e);
            chk("pattern", u_optg_rx.seen[k], e);
        end
    endtask

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        repeat (2) @(posedge ref_clk);
        sys_rst <= 0;
        apb(0, ba(optg_pkg::IDX_PATTERN_CONTROL), 32'h0);
        chk("ctrl reset", rdata, 0);
        apb(1, ba(optg_pkg::IDX_USER_HIGH), 32'hff);
        apb(0, ba(optg_pkg::IDX_USER_HIGH), 32'h0);
        chk("user high", rdata, 32'h0f);
        apb(0, 12'h004, 32'h0);
        chk("pslverr", rerr, 1);
        convWord <= 32'h1234abcd; convValid <= 1;
        repeat (12) @(posedge ref_clk);
        convValid <= 0;
        chk("normal", u_optg_rx.seen[0], {1'b0, 32'h1234abcd});
        chk("genActive off", genActive, 0);
        foreach (rows[i]) run_row(rows[i]);
        apb(1, ba(optg_pkg::IDX_PATTERN_CONTROL), 32'h0);
        repeat (12) @(posedge ref_clk);
        sampleTick <= 1; decimTick <= 0; clear <= 1;
        @(posedge ref_clk) clear <= 0;
        apb(1, ba(optg_pkg::IDX_PATTERN_CONTROL), 32'h11);
        repeat (12) @(posedge ref_clk);
        chk("wrong tick", count, 0);
        end_of_test();
    end
    initial begin
        #(50ns * 20000);
        errors++;
        end_of_test();
    end
endmodule // tb
